// *** include/temp_fmt_pkg.sv ***
package temp_fmt_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_LOCAL = 8'h00;
    localparam logic [7:0] A_R1_HI = 8'h01;
    localparam logic [7:0] A_R1_LO = 8'h10;
    localparam logic [7:0] A_R2_HI = 8'h30;
    localparam logic [7:0] A_R2_LO = 8'h33;
    localparam logic [7:0] A_STATUS = 8'h02;
    localparam logic [7:0] A_CFG_RD = 8'h03;
    localparam logic [7:0] A_CFG_WR = 8'h09;
    localparam logic [7:0] A_RATE_RD = 8'h04;
    localparam logic [7:0] A_RATE_WR = 8'h0a;
    localparam logic [7:0] A_OTSTAT = 8'h23;
    localparam logic [7:0] A_LIM_BASE = 8'h40;
    localparam logic [7:0] A_LIM_LAST = 8'h48;
    // Limit slot within a channel: index = channel * 3 + slot
    localparam int LIM_HI = 0;
    localparam int LIM_LO = 1;
    localparam int LIM_OT = 2;
    // ------------------------------------------------------------
    // Configuration fields and reset values
    // ------------------------------------------------------------
    localparam int CFG_MASK_ALL = 7;
    localparam int CFG_STANDBY = 6;
    localparam int CFG_PIN_MODE = 5;
    localparam int CFG_R2_SEL = 3;
    localparam int CFG_EXT = 2;
    localparam int CFG_MASK_R1 = 1;
    localparam int CFG_MASK_R2 = 0;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] CFG_WR_MASK = 8'hef;
    localparam logic [7:0] RATE_RST = 8'h07;
    localparam logic [7:0] RATE_NOAVG_MIN = 8'h08;
    localparam logic [7:0] LIM_HI_RST = 8'h55;
    localparam logic [7:0] LIM_LO_RST = 8'h00;
    localparam logic [7:0] LIM_OT_RST = 8'h55;
    localparam logic [8:0][7:0] LIM_RST =
        {3{LIM_OT_RST, LIM_LO_RST, LIM_HI_RST}};
    // Bus address of the device; value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h2a;
    // ------------------------------------------------------------
    // Conversion and coding
    // ------------------------------------------------------------
    localparam logic [3:0] AVG_LAST = 4'hf;
    localparam logic signed [12:0] EXT_OFFSET_Q = 13'sh100;
    localparam logic signed [12:0] DEF_MAX_Q = 13'sh1ff;
    localparam logic signed [12:0] EXT_MAX_Q = 13'sh3ff;

    typedef enum logic [1:0] {C_IDLE, C_START, C_WAIT, C_STORE} conv_t;

    typedef struct packed {
        conv_t cst;
        logic [1:0] chan;
        logic [3:0] navg;
        logic avg;
        logic signed [15:0] acc;
        logic conv_start;
        logic [2:0][7:0] hi;
        logic [2:0][1:0] lo;
        logic [2:0] frozen;
        logic [7:0] cfg;
        logic [7:0] rate;
        logic [8:0][7:0] lim;
        logic [7:0] status;
        logic [2:0] otstat;
        logic alert_n;
        logic otemp_n;
    } fmt_regs_t;

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_ACK, S_WBYTE, S_RDATA, S_RACK, S_RLOAD
    } bus_t;

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_prev;
        logic sda_prev;
        bus_t st;
        logic [7:0] sh;
        logic [2:0] cnt;
        logic rw;
        logic first;
        logic ack_on;
        logic oe;
        logic [7:0] ptr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } slave_regs_t;
endpackage : temp_fmt_pkg

// *** include/reg_link_if.sv ***
`timescale 1ns/1ns
interface reg_link_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    modport bus_end (output addr, output wdata, output wr, output rd,
                     input rdata);
    modport reg_end (input addr, input wdata, input wr, input rd,
                     output rdata);
endinterface : reg_link_if

// *** src/mgmt_bus_slave.sv ***
`timescale 1ns/1ns
module mgmt_bus_slave
    import temp_fmt_pkg::*;
(
    input logic mclk,
    input logic resetn,
    input logic scl,
    input logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    reg_link_if.bus_end link
);
    slave_regs_t q, d;
    logic scl_s, sda_s, rise, fall, start, stop;

    assign scl_s = q.scl_sync[1];
    assign sda_s = q.sda_sync[1];
    assign rise = scl_s & ~q.scl_prev;
    assign fall = ~scl_s & q.scl_prev;
    assign start = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
    assign stop = scl_s & q.scl_prev & ~q.sda_prev & sda_s;

    always_comb begin
        d = q;
        d.wr = 1'b0;
        d.rd = 1'b0;
        d.scl_sync = {q.scl_sync[0], scl};
        d.sda_sync = {q.sda_sync[0], sda_in};
        d.scl_prev = scl_s;
        d.sda_prev = sda_s;
        if (start) begin
            d.st = S_ADDR;
            d.cnt = 3'h0;
            d.oe = 1'b0;
            d.ack_on = 1'b0;
        end else if (stop) begin
            d.st = S_IDLE;
            d.oe = 1'b0;
        end else begin
            case (q.st)
                S_ADDR: if (rise) begin
                    d.sh = {q.sh[6:0], sda_s};
                    d.cnt = q.cnt + 3'h1;
                    if (q.cnt == 3'h7) begin
                        d.rw = sda_s;
                        d.first = ~sda_s;
                        d.st = (q.sh[6:0] == DEV_ADDR) ? S_ACK : S_IDLE;
                    end
                end
                S_ACK: if (fall) begin
                    d.ack_on = ~q.ack_on;
                    d.oe = ~q.ack_on;
                    d.cnt = 3'h0;
                    if (q.ack_on && q.rw) begin
                        // Read data is fetched when the byte starts out
                        d.sh = link.rdata;
                        d.oe = ~link.rdata[7];
                        d.rd = 1'b1;
                        d.st = S_RDATA;
                    end else if (q.ack_on) begin
                        d.st = S_WBYTE;
                    end
                end
                S_WBYTE: if (rise) begin
                    d.sh = {q.sh[6:0], sda_s};
                    d.cnt = q.cnt + 3'h1;
                    if (q.cnt == 3'h7) begin
                        d.st = S_ACK;
                        d.first = 1'b0;
                        if (q.first) begin
                            d.ptr = {q.sh[6:0], sda_s};
                        end else begin
                            d.wr = 1'b1;  // see R19
                            d.wdata = {q.sh[6:0], sda_s};
                        end
                    end
                end
                S_RDATA: if (rise) begin
                    d.cnt = q.cnt + 3'h1;
                    if (q.cnt == 3'h7) begin
                        d.st = S_RACK;
                    end
                end else if (fall) begin
                    d.sh = {q.sh[6:0], 1'b0};
                    d.oe = ~q.sh[6];
                end
                S_RACK: if (fall) begin
                    d.oe = 1'b0;
                end else if (rise) begin
                    d.st = sda_s ? S_IDLE : S_RLOAD;
                end
                S_RLOAD: if (fall) begin
                    d.sh = link.rdata;
                    d.oe = ~link.rdata[7];
                    d.rd = 1'b1;
                    d.cnt = 3'h0;
                    d.st = S_RDATA;
                end
                default: d.st = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            q <= '0;
            q.scl_sync <= 2'h3;
            q.sda_sync <= 2'h3;
            q.scl_prev <= 1'b1;
            q.sda_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = q.oe;
    assign link.addr = q.ptr;
    assign link.wdata = q.wdata;
    assign link.wr = q.wr;
    assign link.rd = q.rd;

    sequence addr_hit_s;
        q.st == S_ADDR && rise && q.cnt == 3'h7 && q.sh[6:0] == DEV_ADDR;
    endsequence
    addr_ack_a: assert property (@(posedge mclk) // see R19
        disable iff (!resetn) addr_hit_s |-> ##[1:40] q.oe)
        else $error("address match not acknowledged");
endmodule : mgmt_bus_slave

// *** src/temperature_result_formatter.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// R1: Converter cycles local, remote one, remote two.
// R2: Limit violations set sticky status flags.
// R3: Alert low on high, low, open diode.
// R4: Overtemp output low above overtemp limit.
// R5: Config bit turns alert into second overtemp.
// R6: Average sixteen samples except at fast rates.
// R7: Local eight bits; remote ten bits, split.
// R8: Config bit three maps remote two reads.
// R9: Remote low byte bits seven, six: quarters.
// R10: Low byte read freezes high byte.
// R11: Host reads low byte before high byte.
// R12: Config bit two selects extended range.
// R13: New range valid from next measurement; the code also recodes the result in progress when the range changes.
// R14: Extended range adds sixty-four offset coding.
// R15: Extended values span minus 64 to 191.
// R16: Default range saturates at 0 and 127.
// R17: Range change recodes results, not limits.
// R18: Host rewrites limits after range change.
// R19: All registers readable, limits and config writable.
// R20: Remote low byte bits five to zero zero.
module temperature_result_formatter
    import temp_fmt_pkg::*;
(
    input logic mclk,
    input logic resetn,
    input logic sclk,
    input logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [1:0] mux_sel,
    output logic conv_start,
    input logic meas_valid,
    input logic signed [11:0] meas_temp,
    input logic [1:0] diode_open,
    output logic alert_out_n,
    output logic alert_oe,
    output logic overtemp_out_n,
    output logic overtemp_oe
);
    fmt_regs_t q, d;
    reg_link_if link ();
    logic [2:0] hi_lvl;
    logic [2:0] lo_lvl;
    logic [2:0] ot_lvl;
    logic [1:0] rsel;
    logic signed [11:0] mean;
    logic [9:0] code;
    logic [7:0] set_st;
    logic [7:0] amask;
    logic in_lim;
    logic [3:0] lim_idx;
    logic lo_grab;
    logic store_ok;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    mgmt_bus_slave u_bus (
        .mclk(mclk),
        .resetn(resetn),
        .scl(sclk),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .link(link)
    );

    // ------------------------------------------------------------
    // Coding of a raw quarter-degree result
    // ------------------------------------------------------------
    function automatic logic [9:0] fmt(input logic signed [11:0] t,
                                       input logic ext);
        logic signed [12:0] v;
        logic signed [12:0] top;
        v = {t[11], t};
        top = DEF_MAX_Q;
        if (ext) begin
            v = v + EXT_OFFSET_Q;  // see R14
            top = EXT_MAX_Q;  // see R15
        end
        if (v < 13'sh0000) begin
            fmt = 10'h000;  // see R16
        end else if (v > top) begin
            fmt = top[9:0];  // see R16
        end else begin
            fmt = v[9:0];
        end
    endfunction : fmt

    // ------------------------------------------------------------
    // Limit comparison
    // ------------------------------------------------------------
    // Limits are compared in whatever coding they were written in;
    // nothing here translates them when the range changes.
    for (genvar c = 0; c < 3; c++) begin : g_cmp
        assign hi_lvl[c] = q.hi[c] > q.lim[c * 3 + LIM_HI];  // see R2
        assign lo_lvl[c] = q.hi[c] < q.lim[c * 3 + LIM_LO];  // see R2
        assign ot_lvl[c] = q.hi[c] > q.lim[c * 3 + LIM_OT];  // see R4
    end

    assign rsel = q.cfg[CFG_R2_SEL] ? 2'h2 : 2'h1;  // see R8
    assign mean = q.avg ? q.acc[15:4] : q.acc[11:0];  // see R6
    assign code = fmt(mean, q.cfg[CFG_EXT]);  // see R12
    assign set_st = {diode_open[1], diode_open[0],
                     lo_lvl[2], hi_lvl[2], lo_lvl[1], hi_lvl[1],
                     lo_lvl[0], hi_lvl[0]};
    assign amask = {~q.cfg[CFG_MASK_R2], ~q.cfg[CFG_MASK_R1],
                    {2{~q.cfg[CFG_MASK_R2]}}, {2{~q.cfg[CFG_MASK_R1]}},
                    2'h3};
    assign in_lim = link.addr >= A_LIM_BASE && link.addr <= A_LIM_LAST;
    assign lim_idx = 4'(link.addr - A_LIM_BASE);
    // A low read landing in the store cycle must hold that store too
    assign lo_grab = link.rd && ((link.addr == A_R1_LO && rsel == q.chan)
                     || (link.addr == A_R2_LO && q.chan == 2'h2));
    assign store_ok = q.cst == C_STORE && !q.frozen[q.chan] && !lo_grab;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb begin
        if (link.addr == A_LOCAL) begin
            link.rdata = q.hi[0];  // see R7
        end else if (link.addr == A_R1_HI) begin
            link.rdata = q.hi[rsel];  // see R8
        end else if (link.addr == A_R1_LO) begin
            link.rdata = {q.lo[rsel], 6'h00};  // see R9, see R20
        end else if (link.addr == A_R2_HI) begin
            link.rdata = q.hi[2];
        end else if (link.addr == A_R2_LO) begin
            link.rdata = {q.lo[2], 6'h00};  // see R9, see R20
        end else if (link.addr == A_STATUS) begin
            link.rdata = q.status;
        end else if (link.addr == A_CFG_RD) begin
            link.rdata = q.cfg;
        end else if (link.addr == A_RATE_RD) begin
            link.rdata = q.rate;
        end else if (link.addr == A_OTSTAT) begin
            link.rdata = {5'h00, q.otstat};
        end else if (in_lim) begin
            link.rdata = q.lim[lim_idx];  // see R19
        end else begin
            link.rdata = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.conv_start = 1'b0;
        case (q.cst)
            C_IDLE: begin
                if (!q.cfg[CFG_STANDBY]) begin
                    d.cst = C_START;  // see R1
                end
            end
            C_START: begin
                d.conv_start = 1'b1;
                d.cst = C_WAIT;
                if (q.navg == 4'h0) begin
                    // Fixed per result so a rate write cannot split it
                    d.avg = q.rate < RATE_NOAVG_MIN;  // see R6
                end
            end
            C_WAIT: begin
                if (meas_valid) begin
                    d.acc = q.acc + {{4{meas_temp[11]}}, meas_temp};
                    if (q.avg && q.navg != AVG_LAST) begin
                        d.navg = q.navg + 4'h1;  // see R6
                        d.cst = C_START;
                    end else begin
                        d.cst = C_STORE;
                    end
                end
            end
            C_STORE: begin
                // Coding is taken from the range in force right now, so
                // the first result after a change is already recoded.
                if (!q.frozen[q.chan] && !lo_grab) begin  // see R10
                    d.hi[q.chan] = code[9:2];  // see R7, see R13, see R17
                    d.lo[q.chan] = code[1:0];  // see R7
                end
                d.chan = (q.chan == 2'h2) ? 2'h0 : q.chan + 2'h1;  // see R1
                d.acc = 16'sh0000;
                d.navg = 4'h0;
                d.cst = C_IDLE;
            end
            default: d.cst = C_IDLE;
        endcase

        // Flags: a new violation wins over a clearing read
        d.status = q.status | set_st;  // see R2
        d.otstat = q.otstat | ot_lvl;  // see R2
        if (link.rd && link.addr == A_STATUS) begin
            d.status = set_st;
        end
        if (link.rd && link.addr == A_OTSTAT) begin
            d.otstat = ot_lvl;
        end

        // Low byte read holds its high byte until that is read
        if (link.rd && link.addr == A_R1_LO) begin
            d.frozen[rsel] = 1'b1;  // see R10
        end else if (link.rd && link.addr == A_R1_HI) begin
            d.frozen[rsel] = 1'b0;  // see R10
        end else if (link.rd && link.addr == A_R2_LO) begin
            d.frozen[2] = 1'b1;  // see R10
        end else if (link.rd && link.addr == A_R2_HI) begin
            d.frozen[2] = 1'b0;  // see R10
        end

        if (link.wr && link.addr == A_CFG_WR) begin
            d.cfg = link.wdata & CFG_WR_MASK;  // see R19
        end else if (link.wr && link.addr == A_RATE_WR) begin
            d.rate = link.wdata;  // see R19
        end else if (link.wr && in_lim) begin
            d.lim[lim_idx] = link.wdata;  // see R19
        end

        if (q.cfg[CFG_PIN_MODE]) begin
            d.alert_n = ~|hi_lvl;  // see R5
        end else begin
            d.alert_n = ~(~q.cfg[CFG_MASK_ALL] &
                          |(q.status & amask));  // see R3
        end
        d.otemp_n = ~|ot_lvl;  // see R4
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            q <= '0;
            q.cfg <= CFG_RST;
            q.rate <= RATE_RST;
            q.lim <= LIM_RST;
            q.alert_n <= 1'b1;
            q.otemp_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign mux_sel = q.chan;
    assign conv_start = q.conv_start;
    assign alert_out_n = q.alert_n;
    assign alert_oe = ~q.alert_n;
    assign overtemp_out_n = q.otemp_n;
    assign overtemp_oe = ~q.otemp_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    conv_store_a: assert property ( // see R1
        store_ok |=>
            q.hi[$past(q.chan)] == $past(code[9:2]))
        else $error("result not stored in its channel");

    chan_step_a: assert property ( // see R1
        (q.cst == C_STORE && q.chan == 2'h2) |=> q.chan == 2'h0)
        else $error("channel sequence did not wrap");

    avg_count_a: assert property ( // see R6
        q.cst == C_STORE |->
            (q.avg ? q.navg == AVG_LAST : q.navg == 4'h0))
        else $error("wrong number of averaged samples");

    status_set_a: assert property ( // see R2
        set_st[2] |=> q.status[2])
        else $error("violation flag lost");

    alert_low_a: assert property ( // see R3
        (!q.cfg[CFG_PIN_MODE] && !q.cfg[CFG_MASK_ALL] && q.status[0]
         && $stable(q.cfg)) |=> !alert_out_n && alert_oe)
        else $error("alert not asserted");

    otemp_low_a: assert property ( // see R4
        (|ot_lvl) |=> !overtemp_out_n ##0 overtemp_oe)
        else $error("overtemp output not asserted");

    pin_mode_a: assert property ( // see R5
        (q.cfg[CFG_PIN_MODE] && !(|hi_lvl)) |=> alert_out_n)
        else $error("second overtemp output wrong");

    remap_read_a: assert property ( // see R8
        (link.addr == A_R1_HI && q.cfg[CFG_R2_SEL]) |->
            link.rdata == q.hi[2])
        else $error("remote two not mapped");

    low_byte_a: assert property ( // see R20
        (link.addr == A_R2_LO || link.addr == A_R1_LO) |->
            link.rdata[5:0] == 6'h00)
        else $error("low byte unused bits set");

    sequence r2_lo_rd_s;
        link.rd && link.addr == A_R2_LO;
    endsequence
    sequence r2_hold_s;
        q.frozen[2] && q.cst == C_STORE && q.chan == 2'h2;
    endsequence
    freeze_set_a: assert property ( // see R10
        r2_lo_rd_s |=> q.frozen[2])
        else $error("low read did not freeze");

    freeze_hold_a: assert property ( // see R10
        r2_hold_s |=> $stable(q.hi[2]))
        else $error("frozen high byte changed");

    clamp_def_a: assert property ( // see R16
        (store_ok && !q.cfg[CFG_EXT])
            |=> !q.hi[$past(q.chan)][7])
        else $error("default range not saturated");

    limit_keep_a: assert property ( // see R17
        (link.wr && link.addr == A_CFG_WR) |=> $stable(q.lim))
        else $error("limits changed with range");

    flag_clear_a: assert property ( // see R2
        (link.rd && link.addr == A_STATUS) |=> q.status == $past(set_st))
        else $error("status not cleared by read");

    ot_clear_a: assert property ( // see R4
        (~|ot_lvl) |=> overtemp_out_n && !overtemp_oe)
        else $error("overtemp output stuck low");

    remap_low_a: assert property ( // see R8
        (link.addr == A_R1_LO && q.cfg[CFG_R2_SEL]) |->
            link.rdata[7:6] == q.lo[2])
        else $error("remote two low byte not mapped");

    store_block_a: assert property ( // see R10
        (q.cst == C_STORE && (q.frozen[q.chan] || lo_grab))
            |=> $stable(q.hi))
        else $error("held result overwritten");

    ext_offset_a: assert property ( // see R14
        (store_ok && q.cfg[CFG_EXT] && !mean[11])
            |=> q.hi[$past(q.chan)] >= 8'h40)
        else $error("extended coding lacks offset");

    clamp_neg_a: assert property ( // see R16
        (store_ok && !q.cfg[CFG_EXT] && mean[11])
            |=> q.hi[$past(q.chan)] == 8'h00)
        else $error("negative result not clamped");
endmodule : temperature_result_formatter

// *** tb/bus_host.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Host on the two-wire bus; SCL stands high between frames
// ------------------------------------------------------------
module bus_host
    import temp_fmt_pkg::*;
(
    input wire logic mclk,
    output logic scl,
    output logic sda_o,
    input wire logic sda_i
);
    initial begin
        scl = 1'b1;
        sda_o = 1'b1;
    end
    task automatic put(input logic c, input logic d);
        scl <= c;
        sda_o <= d;
        repeat (5) @(posedge mclk);
    endtask : put
    task automatic bit_out(input logic b);
        put(1'b0, b);
        put(1'b1, b);
        put(1'b1, b);
        put(1'b0, b);
    endtask : bit_out
    // Sampled mid-high so the device's synchroniser has settled
    task automatic bit_in(output logic b);
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
        b = sda_i;
        put(1'b1, 1'b1);
        put(1'b0, 1'b1);
    endtask : bit_in
    task automatic start();
        put(scl, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
        put(1'b0, 1'b0);
    endtask : start
    task automatic stop();
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
        put(1'b1, 1'b1);
    endtask : stop
    task automatic byte_w(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(a);
    endtask : byte_w
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        start();
        byte_w({DEV_ADDR, 1'b0});
        byte_w(a);
        byte_w(d);
        stop();
    endtask : write_reg
    // Single byte read ends with NACK from the host
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        start();
        byte_w({DEV_ADDR, 1'b0});
        byte_w(a);
        start();
        byte_w({DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(1'b1);
        stop();
    endtask : read_reg
endmodule : bus_host

// *** tb/tb.sv ***
`timescale 1ns/1ns
module tb
    import temp_fmt_pkg::*;
;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic meas_valid = 1'b0;
    logic signed [11:0] meas_temp = 12'sh000;
    logic [1:0] diode_open = 2'h0;
    logic signed [11:0] temp_q [3];
    logic tog = 1'b0;
    int lat = 0;
    logic scl, sda_h, sda_oe, conv_start, alert_out_n, overtemp_out_n;
    logic [1:0] mux_sel;
    logic [7:0] rd;
    wire logic sda;
    int err_count = 0;
    int total_checks = 0;

    always #2 mclk = ~mclk;
    assign sda = sda_h & ~sda_oe;

    temperature_result_formatter dut (.mclk(mclk), .resetn(resetn),
        .sclk(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .mux_sel(mux_sel), .conv_start(conv_start),
        .meas_valid(meas_valid), .meas_temp(meas_temp),
        .diode_open(diode_open), .alert_out_n(alert_out_n),
        .alert_oe(), .overtemp_out_n(overtemp_out_n), .overtemp_oe());
    bus_host host (.mclk(mclk), .scl(scl), .sda_o(sda_h), .sda_i(sda));

    // ------------------------------------------------------------
    // Front end: samples alternate one quarter around the set value,
    // so only a true 16-sample average lands on it exactly
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        meas_valid <= 1'b0;
        if (conv_start) begin
            lat <= 3;
        end else if (lat > 0) begin
            lat <= lat - 1;
            if (lat == 1) begin
                meas_valid <= 1'b1;
                meas_temp <= temp_q[mux_sel] + (tog ? 12'sd1 : -12'sd1);
                tog <= ~tog;
            end
        end
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] s,
                       input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.read_reg(a, rd);
        chk($sformatf("reg %h", a), rd, e);
    endtask : rchk
    task automatic conv();
        repeat (800) @(posedge mclk);
    endtask : conv
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (80000) @(posedge mclk);
        err_count++;
        stop_test();
    end

    initial begin
        temp_q[0] = 12'sd200;
        temp_q[1] = 12'sd102;
        temp_q[2] = -12'sd40;
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        rchk(A_CFG_RD, CFG_RST);
        rchk(A_RATE_RD, RATE_RST);
        conv();
        rchk(A_LOCAL, 8'h32);
        rchk(A_R1_LO, 8'h80);
        rchk(A_R1_HI, 8'h19);
        rchk(A_R2_LO, 8'h00);
        rchk(A_R2_HI, 8'h00);
        chk("alert", {7'h0, alert_out_n}, 8'h01);
        chk("overtemp", {7'h0, overtemp_out_n}, 8'h01);
        // Low read must hold the high byte across a new conversion
        rchk(A_R1_LO, 8'h80);
        temp_q[1] = 12'sd40;
        conv();
        rchk(A_R1_HI, 8'h19);
        conv();
        rchk(A_R1_HI, 8'h0a);
        temp_q[2] = 12'sd600;
        conv();
        host.write_reg(A_CFG_WR, 8'h08);
        rchk(A_R1_LO, 8'hc0);
        rchk(A_R1_HI, 8'h7f);
        chk("alert", {7'h0, alert_out_n}, 8'h00);
        chk("overtemp", {7'h0, overtemp_out_n}, 8'h00);
        host.write_reg(A_CFG_WR, 8'h0c);
        conv();
        rchk(A_R1_LO, 8'h00);
        rchk(A_R1_HI, 8'hd6);
        rchk(A_LOCAL, 8'h72);
        rchk(A_CFG_RD, 8'h0c);
        rchk(A_LIM_BASE, LIM_HI_RST);
        host.write_reg(A_CFG_WR, 8'h24);
        host.write_reg(A_LIM_BASE, 8'hff);
        host.write_reg(A_LIM_BASE + 8'h06, 8'hff);
        rchk(A_LIM_BASE + 8'h06, 8'hff);
        conv();
        chk("alert", {7'h0, alert_out_n}, 8'h01);
        chk("overtemp", {7'h0, overtemp_out_n}, 8'h00);
        // Back in alert mode the sticky flags pull the pin again
        host.write_reg(A_CFG_WR, 8'h04);
        repeat (10) @(posedge mclk);
        chk("alert", {7'h0, alert_out_n}, 8'h00);
        rchk(A_OTSTAT, 8'h05);
        rchk(A_STATUS, 8'h11);
        rchk(A_STATUS, 8'h00);
        chk("alert", {7'h0, alert_out_n}, 8'h01);
        diode_open <= 2'h2;
        repeat (4) @(posedge mclk);
        chk("alert", {7'h0, alert_out_n}, 8'h00);
        diode_open <= 2'h0;
        // Single samples sit one quarter off, so the fraction is odd
        host.write_reg(A_RATE_WR, 8'h08);
        conv();
        host.read_reg(A_R1_LO, rd);
        chk("single sample", {7'h0, rd[6]}, 8'h01);
        rchk(8'h7e, 8'h00);
        stop_test();
    end
endmodule : tb
